// ==== testbench/fp_operand_classifier_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module fp_operand_classifier_bench;
  logic        CLOCK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        DENORM_MASK = 1'b1;
  logic        INVALID_MASK = 1'b0;
  logic        op_valid, op_sign, busy, res_valid;
  logic [2:0]  op_code, op_reg_a, op_reg_b, res_class;
  logic [31:0] op_word, res_word;
  logic [9:0]  op_exp;
  logic [23:0] op_sig;
  logic [1:0]  res_cmp;
  logic [79:0] res_ext;
  logic [3:0]  exc, exc_q;
  logic        got_q;
  logic        busy_q;
  logic [8:0]  waits_q;
  int          failures = 0;
  int          n_compared = 0;

  always #12.5 CLOCK = ~CLOCK;

  fpc_core u_fpc_core (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_REG_A(op_reg_a), .OP_REG_B(op_reg_b), .OP_WORD(op_word), .OP_SIGN(op_sign),
    .OP_EXP(op_exp), .OP_SIG(op_sig), .DENORM_MASK(DENORM_MASK),
    .INVALID_MASK(INVALID_MASK), .BUSY(busy), .RES_VALID(res_valid),
    .RES_WORD(res_word), .RES_CLASS(res_class), .RES_CMP(res_cmp), .RES_EXT(res_ext),
    .EXC_INVALID(exc[3]), .EXC_DENORM(exc[2]), .EXC_UNDERFLOW(exc[1]),
    .EXC_OVERFLOW(exc[0]));

  fpc_issuer_model u_fpc_issuer_model (
    .clock(CLOCK), .busy(busy), .res_valid(res_valid), .exc(exc), .op_valid(op_valid),
    .op_code(op_code), .op_reg_a(op_reg_a), .op_reg_b(op_reg_b), .op_word(op_word),
    .op_sign(op_sign), .op_exp(op_exp), .op_sig(op_sig), .exc_q(exc_q), .got_q(got_q),
    .busy_q(busy_q), .waits_q(waits_q));

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // load, then read back through store
  task automatic load_case(input logic [2:0] r, input logic [31:0] w, input logic [2:0] cls);
    u_fpc_issuer_model.issue(fpc_pkg::OP_LOAD, r, 3'h0, w, 1'b0, 10'h0, 24'h0);
    chk(80'(got_q), 80'h1);
    chk(80'(res_class), 80'(cls));
    chk(80'(exc_q[2]), 80'(cls == fpc_pkg::CL_DENORM));
    u_fpc_issuer_model.issue(fpc_pkg::OP_STORE, r, 3'h0, 32'h0, 1'b0, 10'h0, 24'h0);
    chk(80'(res_word), 80'(w));
  endtask : load_case

  task automatic cmp_case(input logic [2:0] a, input logic [2:0] b, input logic [1:0] rel);
    u_fpc_issuer_model.issue(fpc_pkg::OP_COMPARE, a, b, 32'h0, 1'b0, 10'h0, 24'h0);
    chk(80'(res_cmp), 80'(rel));
  endtask : cmp_case

  // x = skip flag checks where the outcome is left open
  task automatic norm_case(input logic s, input logic [9:0] e, input logic [23:0] g,
                           input logic [31:0] w, input logic [2:0] cls,
                           input logic [3:0] ex, input logic x);
    u_fpc_issuer_model.issue(fpc_pkg::OP_NORM, 3'h1, 3'h0, 32'h0, s, e, g);
    chk(80'(busy_q), 80'h1);
    chk(80'(res_word), 80'(w));
    chk(80'(res_class), 80'(cls));
    if (!x)
      chk(80'(exc_q), 80'(ex));
  endtask : norm_case

  task automatic test_classes;
    load_case(3'h0, 32'h00000000, fpc_pkg::CL_ZERO);
    load_case(3'h1, 32'h80000000, fpc_pkg::CL_ZERO);
    load_case(3'h2, 32'h80000001, fpc_pkg::CL_DENORM);
    load_case(3'h3, 32'h43322000, fpc_pkg::CL_NORMAL);
    load_case(3'h4, 32'h00800000, fpc_pkg::CL_NORMAL);
    load_case(3'h5, 32'h7F7FFFFF, fpc_pkg::CL_NORMAL);
    load_case(3'h6, 32'h7F800000, fpc_pkg::CL_INF);
    load_case(3'h7, 32'hFF800000, fpc_pkg::CL_INF);
    load_case(3'h0, 32'h7FC00001, fpc_pkg::CL_QNAN);
    load_case(3'h1, 32'hFF800001, fpc_pkg::CL_SNAN);
    load_case(3'h2, 32'hFFC00000, fpc_pkg::CL_INDEF);
  endtask : test_classes

  task automatic test_extend;
    DENORM_MASK = 1'b1;
    load_case(3'h0, 32'h00000001, fpc_pkg::CL_DENORM);
    chk(res_ext, {1'b0, 15'h3F6A, 64'h8000000000000000});
    load_case(3'h1, 32'h43322000, fpc_pkg::CL_NORMAL);
    chk(res_ext, {1'b0, 15'h4006, 1'b1, 23'h322000, 40'h0});
    DENORM_MASK = 1'b0;
    load_case(3'h2, 32'h00000001, fpc_pkg::CL_DENORM);
    chk(res_ext, {1'b0, 15'h0000, 1'b0, 23'h000001, 40'h0});
    DENORM_MASK = 1'b1;
    u_fpc_issuer_model.issue(fpc_pkg::OP_CLASS, 3'h0, 3'h0, 32'h0, 1'b0, 10'h0, 24'h0);
    chk(80'(res_class), 80'(fpc_pkg::CL_DENORM));
    chk(80'(res_word), 80'h00000001);
    u_fpc_issuer_model.issue(fpc_pkg::OP_NOP, 3'h3, 3'h0, 32'h0, 1'b0, 10'h0, 24'h0);
    chk(80'(got_q), 80'h0);
    chk(80'(res_word), 80'h00000001);
  endtask : test_extend

  task automatic test_compare;
    load_case(3'h0, 32'hFF800000, fpc_pkg::CL_INF);
    load_case(3'h1, 32'hBF800000, fpc_pkg::CL_NORMAL);
    load_case(3'h2, 32'h00000000, fpc_pkg::CL_ZERO);
    load_case(3'h3, 32'h80000000, fpc_pkg::CL_ZERO);
    load_case(3'h4, 32'h7F800000, fpc_pkg::CL_INF);
    load_case(3'h5, 32'h7FC00000, fpc_pkg::CL_QNAN);
    load_case(3'h6, 32'h7FA00000, fpc_pkg::CL_SNAN);
    load_case(3'h7, 32'h00000001, fpc_pkg::CL_DENORM);
    cmp_case(3'h0, 3'h1, fpc_pkg::CMP_LT);
    cmp_case(3'h4, 3'h1, fpc_pkg::CMP_GT);
    cmp_case(3'h1, 3'h4, fpc_pkg::CMP_LT);
    cmp_case(3'h4, 3'h0, fpc_pkg::CMP_GT);
    cmp_case(3'h2, 3'h3, fpc_pkg::CMP_EQ);
    cmp_case(3'h5, 3'h1, fpc_pkg::CMP_UN);
    cmp_case(3'h7, 3'h2, fpc_pkg::CMP_GT);
    chk(80'(exc_q[2]), 80'h1);
    cmp_case(3'h6, 3'h1, fpc_pkg::CMP_UN);
    chk(80'(exc_q[3]), 80'h1);
    INVALID_MASK = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(80'(res_word), 80'h7FA00000);
    cmp_case(3'h6, 3'h1, fpc_pkg::CMP_UN);
    chk(80'(res_word), 80'(fpc_pkg::INDEF));
    chk(80'(res_class), 80'(fpc_pkg::CL_INDEF));
    chk(80'(exc_q[3]), 80'h1);
    INVALID_MASK = 1'b0;
  endtask : test_compare

  task automatic test_normalize;
    norm_case(1'b0, 10'h005, 24'h0C0000, 32'h00C00000, fpc_pkg::CL_NORMAL, 4'h0, 1'b0);
    chk(80'(waits_q), 80'h1);
    norm_case(1'b0, 10'h3FE, 24'hAE0000, 32'h0015C000, fpc_pkg::CL_DENORM, 4'h2, 1'b0);
    chk(80'(waits_q), 80'h4);
    norm_case(1'b0, 10'h3E0, 24'h800000, 32'h00000000, fpc_pkg::CL_ZERO, 4'h0, 1'b1);
    chk(80'(waits_q), 80'h1A);
    norm_case(1'b0, 10'h0FE, 24'hFFFFFF, 32'h7F7FFFFF, fpc_pkg::CL_NORMAL, 4'h0, 1'b0);
    norm_case(1'b0, 10'h0FF, 24'h800000, 32'h7F800000, fpc_pkg::CL_INF, 4'h1, 1'b0);
    norm_case(1'b1, 10'h0FF, 24'h800000, 32'hFF800000, fpc_pkg::CL_INF, 4'h1, 1'b0);
    u_fpc_issuer_model.issue(fpc_pkg::OP_STORE, 3'h1, 3'h0, 32'h0, 1'b0, 10'h0, 24'h0);
    chk(80'(res_word), 80'hFF800000);
  endtask : test_normalize

  initial begin
    repeat (30000) @(posedge CLOCK);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge CLOCK);
    @(negedge CLOCK);
    RESET_N = 1'b1;
    test_classes();
    test_extend();
    test_compare();
    test_normalize();
    wrap_up();
  end
endmodule : fp_operand_classifier_bench
`default_nettype wire

// ==== testbench/fpc_issuer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpc_issuer_model (
  input  wire logic        clock,
  input  wire logic        busy,
  input  wire logic        res_valid,
  input  wire logic [3:0]  exc,
  output logic             op_valid,
  output logic [2:0]       op_code,
  output logic [2:0]       op_reg_a,
  output logic [2:0]       op_reg_b,
  output logic [31:0]      op_word,
  output logic             op_sign,
  output logic [9:0]       op_exp,
  output logic [23:0]      op_sig,
  output logic [3:0]       exc_q,
  output logic             got_q,
  output logic             busy_q,
  output logic [8:0]       waits_q
);
  initial begin
    op_valid = 1'b0;
    op_code  = 3'h0;
    op_reg_a = 3'h0;
    op_reg_b = 3'h0;
    op_word  = 32'h0;
    op_sign  = 1'b0;
    op_exp   = 10'h0;
    op_sig   = 24'h0;
    exc_q    = 4'h0;
    got_q    = 1'b0;
    busy_q   = 1'b0;
    waits_q  = 9'h000;
  end

  // released operands must not keep looking valid
  task automatic drop_req;
    op_valid = 1'b0;
    op_word  = ~op_word;
    op_exp   = ~op_exp;
    op_sig   = ~op_sig;
  endtask : drop_req

  // exception pulses last one cycle, so they are latched here
  task automatic issue(input logic [2:0] code, input logic [2:0] ra, input logic [2:0] rb,
                       input logic [31:0] w, input logic s, input logic [9:0] e,
                       input logic [23:0] g);
    int n;
    got_q = 1'b0;
    @(negedge clock);
    while (busy !== 1'b0) @(negedge clock);
    op_valid = 1'b1;
    op_code  = code;
    op_reg_a = ra;
    op_reg_b = rb;
    op_word  = w;
    op_sign  = s;
    op_exp   = e;
    op_sig   = g;
    @(posedge clock);
    #1;
    busy_q = busy;
    for (n = 0; n < 400 && res_valid !== 1'b1; n++) begin
      @(negedge clock);
      drop_req();
      @(posedge clock);
      #1;
    end
    got_q = (res_valid === 1'b1);
    waits_q = 9'(n);
    exc_q = exc;
    @(negedge clock);
    drop_req();
  endtask : issue
endmodule : fpc_issuer_model
`default_nettype wire

// ==== verilog/fpc_cls_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface fpc_cls_if;
  logic [31:0]         word;
  logic                sign;
  logic [7:0]          bexp;
  logic [23:0]         sig;
  fpc_pkg::fpc_class_t cls;
  modport dec (input word, output sign, output bexp, output sig, output cls);
  modport use_side (output word, input sign, input bexp, input sig, input cls);
endinterface : fpc_cls_if
`default_nettype wire

// ==== verilog/fpc_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpc_core (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        OP_VALID,
  input  wire logic [2:0]  OP_CODE,
  input  wire logic [2:0]  OP_REG_A,
  input  wire logic [2:0]  OP_REG_B,
  input  wire logic [31:0] OP_WORD,
  input  wire logic        OP_SIGN,
  input  wire logic [9:0]  OP_EXP,
  input  wire logic [23:0] OP_SIG,
  input  wire logic        DENORM_MASK,
  input  wire logic        INVALID_MASK,
  output logic             BUSY,
  output logic             RES_VALID,
  output logic [31:0]      RES_WORD,
  output logic [2:0]       RES_CLASS,
  output logic [1:0]       RES_CMP,
  output logic [79:0]      RES_EXT,
  output logic             EXC_INVALID,
  output logic             EXC_DENORM,
  output logic             EXC_UNDERFLOW,
  output logic             EXC_OVERFLOW
);
  typedef struct packed {
    logic [fpc_pkg::NREG-1:0][31:0] regs;
    logic [2:0]  op;
    logic [2:0]  dst;
    logic        busy;
    logic        sign;
    logic [9:0]  exp;
    logic [23:0] sig;
    logic        sticky_zero;
    logic        rvalid;
    logic [31:0] rword;
    logic [2:0]  rclass;
    logic [1:0]  rcmp;
    logic [79:0] rext;
    logic        inv;
    logic        den;
    logic        unf;
    logic        ovf;
  } fpc_state_t;

  fpc_state_t s_q, s_d;
  fpc_cls_if ca ();
  fpc_cls_if cb ();
  fpc_decode u_dec_a (.c(ca.dec));
  fpc_decode u_dec_b (.c(cb.dec));

  // eight data registers, operands from decoder
  assign ca.word = (fpc_pkg::fpc_op_t'(OP_CODE) == fpc_pkg::OP_LOAD) ? OP_WORD
                                                                      : s_q.regs[OP_REG_A];
  assign cb.word = s_q.regs[OP_REG_B];

  logic a_nan, b_nan, a_snan, b_snan, a_den, b_den;
  assign a_nan    = (ca.cls == fpc_pkg::CL_QNAN) || (ca.cls == fpc_pkg::CL_SNAN)
                 || (ca.cls == fpc_pkg::CL_INDEF);
  assign b_nan    = (cb.cls == fpc_pkg::CL_QNAN) || (cb.cls == fpc_pkg::CL_SNAN)
                 || (cb.cls == fpc_pkg::CL_INDEF);
  assign a_snan   = (ca.cls == fpc_pkg::CL_SNAN);
  assign b_snan   = (cb.cls == fpc_pkg::CL_SNAN);
  assign a_den    = (ca.cls == fpc_pkg::CL_DENORM);
  assign b_den    = (cb.cls == fpc_pkg::CL_DENORM);

  // leading-zero count of the incoming significand, one bit per entry
  logic [4:0]  lz;
  logic [23:0] found;
  genvar gi;
  generate
    for (gi = 0; gi < fpc_pkg::SIG_W; gi = gi + 1) begin : g_lz
      if (gi == fpc_pkg::SIG_W - 1) begin : g_top
        assign found[gi] = OP_SIG[gi];
      end else begin : g_rest
        assign found[gi] = found[gi+1] | OP_SIG[gi];
      end
    end
  endgenerate
  always_comb begin
    lz = 5'h00;
    for (int k = 0; k < fpc_pkg::SIG_W; k++) begin
      if (!found[k]) lz = lz + 5'h01;
    end
  end

  // shift that lifts the top set fraction bit into the explicit integer bit
  logic [4:0] dlz;
  always_comb begin
    dlz = 5'h00;
    for (int k = 0; k < fpc_pkg::FRAC_W; k++) begin
      if (ca.sig[k]) dlz = 5'(fpc_pkg::FRAC_W - 1 - k);
    end
  end

  // affine compare magnitude keys; both zeros equal
  function automatic logic [1:0] cmp_fn(input logic [31:0] a, input logic [31:0] b);
    logic        az;
    logic        bz;
    logic [31:0] ka;
    logic [31:0] kb;
    az = (a[30:0] == 31'h00000000);
    bz = (b[30:0] == 31'h00000000);
    ka = a[31] ? ~a : (a | 32'h80000000);
    kb = b[31] ? ~b : (b | 32'h80000000);
    if (az && bz) cmp_fn = fpc_pkg::CMP_EQ;
    else if (ka < kb) cmp_fn = fpc_pkg::CMP_LT;
    else if (ka > kb) cmp_fn = fpc_pkg::CMP_GT;
    else cmp_fn = fpc_pkg::CMP_EQ;
  endfunction : cmp_fn

  always_comb begin
    logic [9:0]  e_n;
    logic [23:0] m_n;
    e_n = 10'h000;
    m_n = 24'h000000;
    s_d = s_q;
    s_d.rvalid = 1'b0;
    case (s_q.busy)
      1'b0: begin
        if (OP_VALID) begin
          s_d.op     = OP_CODE;
          s_d.dst    = OP_REG_A;
          s_d.rclass = ca.cls;
          s_d.rcmp   = fpc_pkg::CMP_EQ;
          s_d.rword  = ca.word;
          s_d.inv    = 1'b0;
          s_d.den    = 1'b0;
          s_d.unf    = 1'b0;
          s_d.ovf    = 1'b0;
          case (fpc_pkg::fpc_op_t'(OP_CODE))
            fpc_pkg::OP_LOAD: begin
              s_d.regs[OP_REG_A] = OP_WORD;
              s_d.den = a_den;
              if (a_den && DENORM_MASK) begin
                s_d.rext = {ca.sign, 15'(fpc_pkg::XBIAS_ADJ - 15'(dlz)),
                            64'({ca.sig[22:0], 41'h0} << dlz)};
              end else if (ca.cls == fpc_pkg::CL_NORMAL) begin
                s_d.rext = {ca.sign, 15'(15'(ca.bexp) + fpc_pkg::XBIAS_ADJ),
                            1'b1, ca.sig[22:0], 40'h0};
              end else begin
                s_d.rext = {ca.sign, {15{ca.bexp == fpc_pkg::EXP_MAX}},
                            (ca.bexp == fpc_pkg::EXP_MAX), ca.sig[22:0], 40'h0};
              end
              s_d.rvalid = 1'b1;
            end
            fpc_pkg::OP_CLASS: begin
              s_d.rvalid = 1'b1;
            end
            fpc_pkg::OP_COMPARE: begin
              s_d.rcmp = (a_nan || b_nan) ? fpc_pkg::CMP_UN : cmp_fn(ca.word, cb.word);
              s_d.inv  = a_snan || b_snan;
              s_d.den  = a_den || b_den;
              s_d.rvalid = 1'b1;
            end
            fpc_pkg::OP_NORM: begin
              // old result stands until the normalized word is ready
              s_d.rword  = s_q.rword;
              s_d.rclass = s_q.rclass;
              s_d.rcmp   = s_q.rcmp;
              s_d.sign = OP_SIGN;
              s_d.sticky_zero = 1'b0;
              if (OP_SIG == 24'h000000) begin
                s_d.exp = 10'h000;
                s_d.sig = 24'h000000;
              end else begin
                s_d.sig = OP_SIG << lz;
                s_d.exp = OP_EXP - 10'(lz);
              end
              s_d.busy = 1'b1;
            end
            fpc_pkg::OP_STORE: begin
              s_d.rvalid = 1'b1;
            end
            default: begin
              // nop and unused codes leave every result field untouched
              s_d        = s_q;
              s_d.rvalid = 1'b0;
            end
          endcase
        end
      end
      default: begin
        // exponent is biased and signed in 10 bits; negative means below one
        if (s_q.exp[9] || s_q.exp == 10'h000) begin
          if (s_q.sig == 24'h000000) s_d.exp = 10'h001;
          else begin
            s_d.sig = s_q.sig >> 1;
            s_d.exp = s_q.exp + 10'h001;
          end
        end else begin
          e_n = s_q.exp;
          m_n = s_q.sig;
          s_d.busy   = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.unf    = 1'b0;
          if (!e_n[9] && e_n > 10'(fpc_pkg::EXP_NMAX)) begin
            // overflow to signed infinity; overflow has no mask, so the result is always inf
            s_d.ovf    = 1'b1;
            s_d.rword  = {s_q.sign, fpc_pkg::EXP_MAX, 23'h000000};
            s_d.rclass = fpc_pkg::CL_INF;
          end else if (m_n == 24'h000000) begin
            s_d.rword  = {s_q.sign, 31'h00000000};
            s_d.rclass = fpc_pkg::CL_ZERO;
          end else if (!m_n[23]) begin
            s_d.unf    = 1'b1;
            s_d.rword  = {s_q.sign, 8'h00, m_n[22:0]};
            s_d.rclass = fpc_pkg::CL_DENORM;
          end else begin
            s_d.rword  = {s_q.sign, e_n[7:0], m_n[22:0]};
            s_d.rclass = fpc_pkg::CL_NORMAL;
          end
        end
      end
    endcase
    // masked invalid returns indefinite
    // only on a fresh result; a stale flag must not rewrite held data
    if (s_d.inv && INVALID_MASK && s_d.rvalid) begin
      s_d.rword  = fpc_pkg::INDEF;
      s_d.rclass = fpc_pkg::CL_INDEF;
    end
    // normalized word back into its register
    if (s_q.op == 3'(fpc_pkg::OP_NORM) && s_d.rvalid && s_q.busy) begin
      s_d.regs[s_q.dst] = s_d.rword;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) s_q <= '0;
    else s_q <= s_d;
  end

  assign BUSY          = s_q.busy;
  assign RES_VALID     = s_q.rvalid;
  assign RES_WORD      = s_q.rword;
  assign RES_CLASS     = s_q.rclass;
  assign RES_CMP       = s_q.rcmp;
  assign RES_EXT       = s_q.rext;
  assign EXC_INVALID   = s_q.rvalid & s_q.inv;
  assign EXC_DENORM    = s_q.rvalid & s_q.den;
  assign EXC_UNDERFLOW = s_q.rvalid & s_q.unf;
  assign EXC_OVERFLOW  = s_q.rvalid & s_q.ovf;

  AST_UNF_DENORM: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    EXC_UNDERFLOW |-> (RES_WORD[30:23] == 8'h00 && RES_WORD[22:0] != 23'h000000))
    else $error("underflow without denormal result");
  AST_OVF_INF: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    EXC_OVERFLOW |-> (RES_WORD[30:0] == 31'h7F800000))
    else $error("overflow result not infinity");
  AST_NORM_DONE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (!BUSY && OP_VALID && OP_CODE == 3'(fpc_pkg::OP_NORM)) |-> ##[1:160] RES_VALID)
    else $error("normalize did not finish");
  AST_SNAN_INV: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (!BUSY && OP_VALID && OP_CODE == 3'(fpc_pkg::OP_COMPARE) && (a_snan || b_snan))
    |=> EXC_INVALID)
    else $error("signalling operand not invalid");
  AST_QNAN_QUIET: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (!BUSY && OP_VALID && OP_CODE == 3'(fpc_pkg::OP_COMPARE) && !a_snan && !b_snan)
    |=> !EXC_INVALID)
    else $error("quiet operands raised invalid");
  AST_DEN_SRC: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (!BUSY && OP_VALID && OP_CODE == 3'(fpc_pkg::OP_LOAD) && a_den) |=> EXC_DENORM)
    else $error("denormal operand not flagged");
  AST_ZERO_EQ: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (!BUSY && OP_VALID && OP_CODE == 3'(fpc_pkg::OP_COMPARE)
     && ca.cls == fpc_pkg::CL_ZERO && cb.cls == fpc_pkg::CL_ZERO)
    |=> RES_CMP == fpc_pkg::CMP_EQ)
    else $error("signed zeros not equal");
  AST_INF_CLASS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (RES_VALID && RES_CLASS == 3'(fpc_pkg::CL_INF)) |-> RES_WORD[30:0] == 31'h7F800000)
    else $error("infinity encoding wrong");
  AST_NORM_MSB: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    (RES_VALID && RES_CLASS == 3'(fpc_pkg::CL_NORMAL) && $past(BUSY))
    |-> RES_WORD[30:23] != 8'h00)
    else $error("normal result with zero exponent");
  AST_WORD_HOLD: assert property (@(posedge CLOCK) disable iff (!RESET_N)
    !RES_VALID |-> $stable(RES_WORD))
    else $error("result word changed without a result");
endmodule : fpc_core
`default_nettype wire

// ==== verilog/fpc_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpc_decode (
  fpc_cls_if.dec c
);
  logic [fpc_pkg::EXP_W-1:0]  e;
  logic [fpc_pkg::FRAC_W-1:0] f;
  assign e = c.word[fpc_pkg::EXP_HI:fpc_pkg::EXP_LO];
  assign f = c.word[fpc_pkg::FRAC_W-1:0];
  assign c.sign = c.word[fpc_pkg::SIGN_POS];
  assign c.bexp = e;
  // implied integer bit, zero for denormals
  assign c.sig = {(e != 8'h00), f};
  always_comb begin
    if (c.word == fpc_pkg::INDEF) begin
      c.cls = fpc_pkg::CL_INDEF;
    end else if (e == fpc_pkg::EXP_MAX) begin
      if (f == 23'h000000) c.cls = fpc_pkg::CL_INF;
      else if (f[fpc_pkg::FRAC_W-1]) c.cls = fpc_pkg::CL_QNAN;
      else c.cls = fpc_pkg::CL_SNAN;
    end else if (e == 8'h00) begin
      c.cls = (f == 23'h000000) ? fpc_pkg::CL_ZERO : fpc_pkg::CL_DENORM;
    end else begin
      c.cls = fpc_pkg::CL_NORMAL;
    end
  end
endmodule : fpc_decode
`default_nettype wire

// ==== verilog/fpc_pkg.sv ====
package fpc_pkg;
  localparam int EXP_W     = 8;
  localparam int FRAC_W    = 23;
  localparam int SIG_W     = FRAC_W + 1;
  localparam int WORD_W    = 1 + EXP_W + FRAC_W;
  localparam int SIGN_POS  = 31;
  localparam int EXP_HI    = 30;
  localparam int EXP_LO    = 23;
  localparam logic [EXP_W-1:0] EXP_MAX  = 8'hFF;
  localparam logic [EXP_W-1:0] EXP_NMIN = 8'h01;
  localparam logic [EXP_W-1:0] EXP_NMAX = 8'hFE;
  localparam logic [9:0]       BIAS     = 10'h07F;
  localparam logic [WORD_W-1:0] INDEF   = 32'hFFC00000;
  localparam int NREG      = 8;
  localparam int REG_IDX_W = 3;
  localparam int XFRAC_W   = 63;
  localparam logic [14:0]      XBIAS_ADJ = 15'h3F80;
  typedef enum logic [2:0] {
    CL_ZERO, CL_DENORM, CL_NORMAL, CL_INF, CL_QNAN, CL_SNAN, CL_INDEF
  } fpc_class_t;
  typedef enum logic [2:0] {
    OP_NOP, OP_LOAD, OP_CLASS, OP_COMPARE, OP_NORM, OP_STORE
  } fpc_op_t;
  typedef enum logic [1:0] {CMP_LT, CMP_EQ, CMP_GT, CMP_UN} fpc_cmp_t;
endpackage : fpc_pkg
